// ==== hdl/tef_timer_event_flags.sv ====
// Interval timer, interrupt and error flags, test-input select and register port
`timescale 1ns/10ps
`include "tef_params.svh"
// How it works
// RULE1 - Timer period register sets delay as count times clock period.
// RULE2 - Period field is 13 bits, delays one to 8191 periods.
// RULE3 - Timer launches on start hit, stop hit, or both, per two enables.
// RULE4 - With expiry mask bit set, interrupt rises when the timer finishes.
// RULE5 - Interrupt output is OR of sources unmasked by bits 13 to 25.
// RULE6 - Interrupt sources: hit full, interface full, PLL unlocked, empty, expiry.
// RULE7 - Error output is OR of sources unmasked by bits 16 to 26.
// RULE8 - Error sources: each hit full, each interface full, PLL unlocked.
// RULE9 - Test-select bit routes three test inputs in place of measure inputs.
// RULE10 - Master reset clears timer and flags, keeps all configuration registers.
// RULE11 - Flags are levels following unmasked sources, cleared by reset.
// RULE12 - Expiry holds until master or partial reset; new launch restarts count.
module tef_timer_event_flags #(
  parameter int DATA_W   = `TEF_DATA_W,
  parameter int PERIOD_W = `TEF_PERIOD_W
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                csn,
  input  wire logic                wrn,
  input  wire logic                rdn,
  input  wire logic [3:0]          adr,
  input  wire logic [DATA_W-1:0]   data_in,
  output logic      [DATA_W-1:0]   data_out,
  output logic                     data_oe,
  input  wire logic                start_hit,
  input  wire logic                stop_hit,
  input  wire tef_pkg::tef_status_t status,
  input  wire logic [2:0]          measure_in,
  input  wire logic [2:0]          test_in,
  output logic [2:0]               meas_path,
  output logic                     interrupt_output,
  output logic                     error_output,
  output logic                     master_reset_pulse,
  output logic                     partial_reset_pulse,
  output logic [4:0]               fine_bin_divider
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYN_W = 3 + 4 + DATA_W + 6;
  logic [SYN_W-1:0] syn_a;
  logic [SYN_W-1:0] syn_b;
  logic             wrn_q;
  logic             csn_s;
  logic             wrn_s;
  logic             rdn_s;
  logic [3:0]       adr_s;
  logic [DATA_W-1:0] din_s;
  logic [2:0]       meas_s;
  logic [2:0]       test_s;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syn_a <= '1;
      syn_b <= '1;
      wrn_q <= 1'b1;
    end else begin
      syn_a <= {csn, wrn, rdn, adr, data_in, measure_in, test_in};
      syn_b <= syn_a;
      wrn_q <= wrn_s;
    end
  end

  assign {csn_s, wrn_s, rdn_s, adr_s, din_s, meas_s, test_s} = syn_b;

  // Write is taken on the rising edge of the write strobe with chip select low
  logic wr_take;
  assign wr_take = wrn_s && !wrn_q && !csn_s;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] test_cfg;
  logic [DATA_W-1:0] control;
  logic [DATA_W-1:0] timer_reg;
  logic [DATA_W-1:0] err_mask;
  logic [DATA_W-1:0] irq_mask;

  // Configuration survives both soft resets; only rstn clears it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      test_cfg  <= `TEF_REG_RESET;
      control   <= `TEF_REG_RESET;
      timer_reg <= `TEF_REG_RESET;
      err_mask  <= `TEF_REG_RESET;
      irq_mask  <= `TEF_REG_RESET;
    end else if (wr_take) begin // see RULE10
      unique case (adr_s)
        `TEF_ADR_TEST_CFG: test_cfg  <= din_s;
        `TEF_ADR_CONTROL: begin
          control <= din_s;
          control[`TEF_MASTER_RST_BIT]  <= 1'b0;
          control[`TEF_PARTIAL_RST_BIT] <= 1'b0;
        end
        `TEF_ADR_TIMER:    timer_reg <= din_s;
        `TEF_ADR_ERR_MASK: err_mask  <= din_s;
        `TEF_ADR_IRQ_MASK: irq_mask  <= din_s;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Soft reset commands
  // ----------------------------------------------------------------
  logic soft_rst;
  assign soft_rst = master_reset_pulse || partial_reset_pulse;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      master_reset_pulse  <= 1'b0;
      partial_reset_pulse <= 1'b0;
    end else begin
      master_reset_pulse  <= wr_take && adr_s == `TEF_ADR_CONTROL
                             && din_s[`TEF_MASTER_RST_BIT];
      partial_reset_pulse <= wr_take && adr_s == `TEF_ADR_CONTROL
                             && din_s[`TEF_PARTIAL_RST_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------
  tef_pkg::tef_timer_state_t tstate;
  logic [PERIOD_W-1:0]       tcount;
  logic                      launch;
  logic                      expired;

  assign launch = (control[`TEF_LAUNCH_START] && start_hit)
               || (control[`TEF_LAUNCH_STOP] && stop_hit); // see RULE3
  assign expired = tstate == tef_pkg::TEF_EXPIRED; // see RULE4

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tstate <= tef_pkg::TEF_IDLE;
      tcount <= '0;
    end else if (soft_rst) begin // see RULE10
      tstate <= tef_pkg::TEF_IDLE; // see RULE12
      tcount <= '0;
    end else if (launch) begin
      tstate <= tef_pkg::TEF_RUN; // see RULE12
      tcount <= timer_reg[PERIOD_W-1:0]; // see RULE1
    end else begin
      unique case (tstate)
        tef_pkg::TEF_IDLE: ;
        tef_pkg::TEF_RUN: begin
          if (tcount <= PERIOD_W'(1)) begin // see RULE2
            tstate <= tef_pkg::TEF_EXPIRED;
          end else begin
            tcount <= tcount - PERIOD_W'(1);
          end
        end
        tef_pkg::TEF_EXPIRED: ; // see RULE12
        default: tstate <= tef_pkg::TEF_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flag outputs
  // ----------------------------------------------------------------
  logic [12:0] irq_src;
  logic [10:0] err_src;
  logic        irq_any;
  logic        err_any;

  assign irq_src = {expired, status.all_empty, status.pll_unlocked,
                    status.iface_full, status.hit_full}; // see RULE6
  assign err_src = {status.pll_unlocked, status.iface_full, status.hit_full}; // see RULE8
  assign irq_any = |(irq_src & irq_mask[`TEF_IRQ_MSB:`TEF_IRQ_LSB]); // see RULE5
  assign err_any = |(err_src & err_mask[`TEF_ERR_MSB:`TEF_ERR_LSB]); // see RULE7

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_output <= 1'b0;
      error_output     <= 1'b0;
    end else if (soft_rst) begin
      interrupt_output <= 1'b0; // see RULE11
      error_output     <= 1'b0;
    end else begin
      interrupt_output <= irq_any; // see RULE5
      error_output     <= err_any; // see RULE7
    end
  end

  // ----------------------------------------------------------------
  // Test-input select and fine divider field
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meas_path        <= 3'h0;
      fine_bin_divider <= 5'h00;
    end else begin
      meas_path        <= test_cfg[`TEF_TEST_SEL_BIT] ? test_s : meas_s; // see RULE9
      fine_bin_divider <= test_cfg[4:0];
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    unique case (adr_s)
      `TEF_ADR_TEST_CFG: rd_mux = test_cfg;
      `TEF_ADR_CONTROL:  rd_mux = control;
      `TEF_ADR_TIMER:    rd_mux = timer_reg;
      `TEF_ADR_ERR_MASK: rd_mux = err_mask;
      `TEF_ADR_IRQ_MASK: rd_mux = irq_mask;
      default:           rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_out <= '0;
      data_oe  <= 1'b0;
    end else begin
      data_oe  <= !rdn_s && !csn_s;
      data_out <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence launch_s;
    launch && !soft_rst && timer_reg[PERIOD_W-1:0] == PERIOD_W'(1);
  endsequence
  sequence quiet_s;
    !launch && !soft_rst;
  endsequence

  timer_one_period_a: assert property (launch_s ##1 quiet_s |=> expired && !$past(expired)) // see RULE1
    else $error("timer did not expire one period after launch");
  timer_run_load_a: assert property (launch && !soft_rst |=> tstate == tef_pkg::TEF_RUN) // see RULE2
    else $error("launch did not start the timer");
  launch_gated_a: assert property (tstate == tef_pkg::TEF_IDLE && !control[`TEF_LAUNCH_START]
      && !control[`TEF_LAUNCH_STOP] |=> tstate == tef_pkg::TEF_IDLE) // see RULE3
    else $error("timer started with both launch enables off");
  expiry_irq_a: assert property (expired && irq_mask[`TEF_IRQ_MSB] && !soft_rst
      |=> interrupt_output) // see RULE4
    else $error("expiry did not raise the interrupt");
  irq_or_a: assert property (!$past(soft_rst) |-> interrupt_output
      == $past(irq_any)) // see RULE5
    else $error("interrupt output not the OR of unmasked sources");
  irq_pll_a: assert property (status.pll_unlocked && irq_mask[23] && !soft_rst
      |=> interrupt_output) // see RULE6
    else $error("PLL unlock did not raise the interrupt");
  err_or_a: assert property (!$past(soft_rst) |-> error_output
      == $past(err_any)) // see RULE7
    else $error("error output not the OR of unmasked sources");
  err_no_expiry_a: assert property ((err_mask[`TEF_ERR_MSB:`TEF_ERR_LSB] & err_src) == '0
      |=> !error_output) // see RULE8
    else $error("error output raised with no unmasked error source");
  test_mux_a: assert property (test_cfg[`TEF_TEST_SEL_BIT] |=> meas_path == $past(test_s)) // see RULE9
    else $error("test inputs not routed to the measuring path");
  mreset_keeps_a: assert property (master_reset_pulse |=> tstate == tef_pkg::TEF_IDLE
      && $stable(irq_mask) && $stable(err_mask) && $stable(timer_reg)) // see RULE10
    else $error("master reset did not clear timer or disturbed configuration");
  flag_reset_a: assert property (soft_rst |=> !interrupt_output && !error_output) // see RULE11
    else $error("flags not cleared by reset");
  expiry_hold_a: assert property (expired && !launch && !soft_rst |=> expired) // see RULE12
    else $error("expiry dropped without reset or relaunch");

endmodule // tef_timer_event_flags

// ==== hdl/tef_params.svh ====
// Offsets, field positions, reset values and timing counts of the timer and event-flag unit
`ifndef TEF_PARAMS_SVH
`define TEF_PARAMS_SVH

`define TEF_DATA_W          28
`define TEF_ADDR_W          4
`define TEF_ADR_TEST_CFG    4'h3
`define TEF_ADR_CONTROL     4'h4
`define TEF_ADR_TIMER       4'h7
`define TEF_ADR_ERR_MASK    4'hB
`define TEF_ADR_IRQ_MASK    4'hC
`define TEF_REG_RESET       28'h0000000

`define TEF_TEST_SEL_BIT    25
`define TEF_LAUNCH_START    10
`define TEF_LAUNCH_STOP     11
`define TEF_MASTER_RST_BIT  22
`define TEF_PARTIAL_RST_BIT 23

`define TEF_PERIOD_W        13
`define TEF_IRQ_LSB         13
`define TEF_IRQ_MSB         25
`define TEF_ERR_LSB         16
`define TEF_ERR_MSB         26

`define TEF_CLK_NS          40
`define TEF_SYNC_STAGES     2

`endif

// ==== hdl/tef_pkg.sv ====
// Types shared by the timer and event-flag unit
package tef_pkg;

  typedef enum logic [1:0] {
    TEF_IDLE,
    TEF_RUN,
    TEF_EXPIRED
  } tef_timer_state_t;

  typedef struct packed {
    logic [7:0] hit_full;
    logic [1:0] iface_full;
    logic       pll_unlocked;
    logic       all_empty;
  } tef_status_t;

endpackage

// ==== dv/tef_host_model.sv ====
// Host processor model that drives the asynchronous register bus
`timescale 1ns/10ps
module tef_host_model (
  input  wire logic        clk,
  output logic             csn,
  output logic             wrn,
  output logic             rdn,
  output logic [3:0]       adr,
  output logic [27:0]      data_in,
  input  wire logic        data_oe
);
  // ----------
  // Bus cycles
  // ----------
  initial begin
    csn = 1'b1;
    wrn = 1'b1;
    rdn = 1'b1;
    adr = 4'h0;
    data_in = 28'h0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [27:0] d);
    step(1);
    adr = a;
    data_in = d;
    csn = 1'b0;
    wrn = 1'b0;
    step(3);
    wrn = 1'b1;
    step(3);
    csn = 1'b1;
    // Released lines must not keep showing the written word
    data_in = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output bit ok);
    ok = 1'b0;
    step(1);
    adr = a;
    csn = 1'b0;
    rdn = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk);
      ok = (data_oe === 1'b1);
    end
    #1;
    rdn = 1'b1;
    csn = 1'b1;
    step(4);
  endtask
endmodule // tef_host_model

// ==== dv/timer_event_flags_bench.sv ====
// Self-checking bench of the timer and event-flag unit
`timescale 1ns/10ps
`include "tef_params.svh"
module timer_event_flags_bench;
  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  logic                 csn, wrn, rdn, data_oe, irq, err;
  logic [3:0]           adr;
  logic [27:0]          data_in, data_out, m11, m12;
  logic                 start_hit = 1'b0;
  logic                 stop_hit = 1'b0;
  tef_pkg::tef_status_t status = '0;
  logic [2:0]           measure_in = 3'h0;
  logic [2:0]           test_in = 3'h0;
  logic [2:0]           meas_path;
  logic [4:0]           fbd;
  logic                 oe_q = 1'b0;
  logic                 mrp, prp;
  int                   mr_n = 0;
  int                   pr_n = 0;
  logic [27:0]          expq[$];
  int                   fails = 0;
  int                   checks = 0;
  integer               seed = 32'hbb11;
  int                   n, i;

  always #20 clk = ~clk;

  tef_host_model host (.clk(clk), .csn(csn), .wrn(wrn), .rdn(rdn), .adr(adr),
                       .data_in(data_in), .data_oe(data_oe));
  tef_timer_event_flags DUT (.clk(clk), .rstn(rstn), .csn(csn), .wrn(wrn), .rdn(rdn),
    .adr(adr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .start_hit(start_hit), .stop_hit(stop_hit), .status(status),
    .measure_in(measure_in), .test_in(test_in), .meas_path(meas_path),
    .interrupt_output(irq), .error_output(err), .master_reset_pulse(mrp),
    .partial_reset_pulse(prp), .fine_bin_divider(fbd));

  // ------------------
  // Checking utilities
  // ------------------
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Each read result is matched against the oldest noted expectation
  always @(posedge clk) begin
    if (data_oe === 1'b1 && oe_q !== 1'b1) begin
      if (expq.size() == 0)
        check(data_out, 28'hFFFFFFF);
      else
        check(data_out, expq.pop_front());
    end
    oe_q <= data_oe;
  end
  // Soft reset pulses are counted mid-cycle, where they stand settled
  always @(negedge clk) begin
    if (mrp === 1'b1)
      mr_n++;
    if (prp === 1'b1)
      pr_n++;
  end
  task automatic rd(input logic [3:0] a, input logic [27:0] e);
    bit ok;
    expq.push_back(e);
    host.rd(a, ok);
    if (!ok) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input bit stp);
    tick(1);
    start_hit = !stp;
    stop_hit = stp;
    tick(1);
    start_hit = 1'b0;
    stop_hit = 1'b0;
  endtask
  function automatic logic x_irq(input logic [27:0] m, input tef_pkg::tef_status_t s);
    return |({1'b0, s.all_empty, s.pll_unlocked, s.iface_full, s.hit_full} & m[25:13]);
  endfunction
  function automatic logic x_err(input logic [27:0] m, input tef_pkg::tef_status_t s);
    return |({s.pll_unlocked, s.iface_full, s.hit_full} & m[26:16]);
  endfunction

  initial begin
    tick(3);
    rstn = 1'b1;
    rd(`TEF_ADR_TIMER, `TEF_REG_RESET);
    rd(`TEF_ADR_ERR_MASK, `TEF_REG_RESET);
    rd(`TEF_ADR_IRQ_MASK, `TEF_REG_RESET);
    host.wr(4'h5, 28'hFFFFFFF);
    rd(4'h5, 28'h0);
    for (int j = 0; j < 2; j++) begin
      m11 = j ? 28'($random(seed)) : 28'h7FF0000;
      m12 = j ? 28'($random(seed)) & 28'h1FFE000 : 28'h1FFE000;
      host.wr(`TEF_ADR_ERR_MASK, m11);
      host.wr(`TEF_ADR_IRQ_MASK, m12);
      rd(`TEF_ADR_ERR_MASK, m11);
      rd(`TEF_ADR_IRQ_MASK, m12);
      for (int k = 0; k < 24; k++) begin
        status = tef_pkg::tef_status_t'((k < 12) ? 12'h1 << k : 12'($random(seed)));
        tick(3);
        check(irq, x_irq(m12, status));
        check(err, x_err(m11, status));
      end
      status = '0;
      tick(3);
      check({irq, err}, 2'b00);
    end
    host.wr(`TEF_ADR_IRQ_MASK, 28'h2000000);
    for (int k = 0; k < 2; k++) begin
      n = k ? 8191 : 1;
      host.wr(`TEF_ADR_TIMER, 28'(n));
      host.wr(`TEF_ADR_CONTROL, (28'h1 << `TEF_MASTER_RST_BIT) | (28'h1 << (10 + k)));
      tick(3);
      check(irq, 1'b0);
      pulse(!k);
      tick(n + 4);
      check(irq, 1'b0);
      pulse(k);
      for (i = 0; irq !== 1'b1 && i < n + 8; i++)
        tick(1);
      check(28'(i), 28'(n + 1));
      if (irq !== 1'b1)
        report_and_stop();
      tick(10);
      check(irq, 1'b1);
      check(err, 1'b0);
      rd(`TEF_ADR_CONTROL, 28'h1 << (10 + k));
      rd(`TEF_ADR_TIMER, 28'(n));
    end
    host.wr(`TEF_ADR_CONTROL, 28'h1 << `TEF_PARTIAL_RST_BIT);
    tick(3);
    check(irq, 1'b0);
    for (int k = 0; k < 2; k++) begin
      host.wr(`TEF_ADR_TEST_CFG, (28'(k) << `TEF_TEST_SEL_BIT) | 28'h15);
      measure_in = 3'($random(seed));
      test_in = ~measure_in;
      tick(4);
      check(meas_path, k ? test_in : measure_in);
      check(fbd, 5'h15);
    end
    check(28'(mr_n), 28'h0000002);
    check(28'(pr_n), 28'h0000001);
    report_and_stop();
  end
endmodule // timer_event_flags_bench
